// File: bench/arc_ref_chk.sv
`timescale 1ns/1ps
module arc_ref_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic cmp_high,
  input wire logic [arc_pkg::ARC_BITS-1:0] dac_trial,
  input wire logic track_active,
  input wire logic converter_on,
  input wire logic converter_shutdown,
  input wire logic [arc_pkg::ARC_SEL_W-1:0] negative_channel_select,
  input wire logic differential_mode,
  input wire logic ref_buffer_gain_unity,
  input wire logic ref_from_regulator,
  input wire logic ref_from_supply,
  input wire logic ref_from_pin,
  input wire logic temp_sensor_on,
  input wire logic bias_generator_on,
  input wire logic ref_buffer_drive
);
  import arc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wref;
  logic start;
  assign wref = sfr_wr && sfr_addr == ARC_ADDR_REF_CTRL;
  assign start = sfr_wr && sfr_addr == ARC_ADDR_CONV_CTRL && sfr_wdata[7] && sfr_wdata[4];
  AST_SHUT: assert property (converter_shutdown == !converter_on)
    else $error("shutdown is not the inverse of enable");
  AST_IDLE: assert property (!converter_on |-> dac_trial == '0 && !track_active)
    else $error("converter active while disabled");
  AST_DIFF: assert property (!$past(rst) |-> differential_mode == (negative_channel_select != 5'h1F))
    else $error("mode does not follow negative select");
  AST_PIN: assert property (ref_from_pin == (!ref_from_regulator && !ref_from_supply))
    else $error("reference pin choice wrong");
  AST_OVR: assert property (ref_from_regulator |-> !ref_from_supply && !ref_from_pin)
    else $error("regulator override ignored");
  AST_RD65: assert property (sfr_rd && sfr_addr == ARC_ADDR_REF_CTRL |=> sfr_rdata[6:5] == 2'h0)
    else $error("unused reference bits read nonzero");
  AST_WRA: assert property (wref ##1 !wref |=> ref_buffer_gain_unity == $past(sfr_wdata[7], 2) && temp_sensor_on == $past(sfr_wdata[2], 2))
    else $error("gain or sensor output wrong after write");
  AST_WRB: assert property (wref ##1 !wref |=> bias_generator_on == $past(sfr_wdata[1], 2) && ref_buffer_drive == $past(sfr_wdata[0], 2))
    else $error("bias or buffer output wrong after write");
  AST_TRACK: assert property (start && !track_active && dac_trial == '0 |=> track_active[*5] ##1 track_active[*5] ##1 (!track_active && dac_trial == 10'h200))
    else $error("track phase length wrong");
  AST_SAR: assert property (dac_trial == 10'h200 && !track_active |=> dac_trial[9] == $past(cmp_high) && dac_trial[8])
    else $error("first trial bit not resolved from comparator");
  CV_START: cover property (start ##1 track_active);
  CV_SINGLE: cover property (converter_on && !differential_mode);
  CV_REGREF: cover property (ref_from_regulator && ref_buffer_drive);
endmodule // arc_ref_chk
bind arc_adc_ref_ctrl arc_ref_chk i_arc_ref_chk (.*);

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import arc_pkg::*;
  logic clk_sys, rst, sfr_wr, sfr_rd, cmp_high;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [ARC_BITS-1:0] dac_trial;
  logic [ARC_SEL_W-1:0] pos_sel, neg_sel;
  logic track_active, converter_on, converter_shutdown, differential_mode;
  logic gain, reg_ref, sup_ref, pin_ref, temp_on, bias_on, buf_drv;
  int errors = 0;
  int checked = 0;
  arc_adc_ref_ctrl i_arc_adc_ref_ctrl (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_high(cmp_high), .dac_trial(dac_trial), .track_active(track_active),
    .converter_on(converter_on), .converter_shutdown(converter_shutdown),
    .positive_channel_select(pos_sel), .negative_channel_select(neg_sel),
    .differential_mode(differential_mode), .ref_buffer_gain_unity(gain),
    .ref_from_regulator(reg_ref), .ref_from_supply(sup_ref), .ref_from_pin(pin_ref),
    .temp_sensor_on(temp_on), .bias_generator_on(bias_on), .ref_buffer_drive(buf_drv));
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge clk_sys);
    sfr_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge clk_sys);
    sfr_rd <= 1'h0;
    #1;
    chk("read data", {2'h0, sfr_rdata}, {2'h0, e});
  endtask
  task automatic t_reset;
    wt(1);
    chk("idle outputs", {6'h0, converter_shutdown, pin_ref, converter_on, track_active}, 10'h00C);
    rd(ARC_ADDR_REF_CTRL, 8'h00);
    rd(ARC_ADDR_CONV_CTRL, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ref;
    logic [7:0] v [6] = '{8'hFF, 8'h80, 8'h10, 8'h08, 8'h04, 8'h03};
    logic [9:0] e;
    foreach (v[i]) begin
      wr(ARC_ADDR_REF_CTRL, v[i]);
      wt(1);
      e = {3'h0, v[i][7], v[i][4], !v[i][4] && v[i][3], !v[i][4] && !v[i][3], v[i][2:0]};
      chk("ref outputs", {3'h0, gain, reg_ref, sup_ref, pin_ref, temp_on, bias_on, buf_drv}, e);
      rd(ARC_ADDR_REF_CTRL, v[i] & 8'h9F);
    end
    $display("test reference done");
  endtask
  task automatic t_sel;
    wr(ARC_ADDR_POS_SEL, 8'h1E);
    wr(ARC_ADDR_NEG_SEL, 8'h1F);
    wt(1);
    chk("selects", {pos_sel, neg_sel}, {5'h1E, 5'h1F});
    chk("mode", {9'h0, differential_mode}, 10'h000);
    wr(ARC_ADDR_NEG_SEL, 8'h1E);
    wt(1);
    chk("mode", {9'h0, differential_mode}, 10'h001);
    rd(ARC_ADDR_POS_SEL, 8'h1E);
    wr(ARC_ADDR_POS_SEL, 8'h03);
    wt(1);
    chk("pin select", {5'h0, pos_sel}, 10'h003);
    $display("test select done");
  endtask
  task automatic t_conv;
    cmp_high <= 1'h1;
    wr(ARC_ADDR_CONV_CTRL, 8'h90);
    wt(1);
    chk("tracking", {8'h0, converter_on, track_active}, 10'h003);
    wt(9);
    chk("first trial", dac_trial, 10'h200);
    wt(10);
    rd(ARC_ADDR_CONV_CTRL, 8'hA0);
    rd(ARC_ADDR_RESULT_HI, 8'h03);
    rd(ARC_ADDR_RESULT_LO, 8'hFF);
    wr(ARC_ADDR_CONV_CTRL, 8'h00);
    wt(1);
    chk("shutdown", {8'h0, converter_on, converter_shutdown}, 10'h001);
    $display("test conversion done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'h1;
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    cmp_high = 1'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset;
    t_ref;
    t_sel;
    t_conv;
    end_of_test;
  end
  // The tests need under a hundred cycles, so a thousand means a hang.
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule // tb

// File: logic/arc_adc_ref_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Ten-bit successive approximation at 500 ksps.
// - Converter runs only while enable bit set.
// - Positive: pins, temp sensor, supply; negative: pins, reference, ground.
// - Ground negative means single-ended, else differential.
// - Separate positive and negative selection registers.
// - Bit 7: 0 double gain, 1 unity.
// - Bits 6:5 read zero, writes ignored.
// - Bit 4 forces regulator as reference.
// - Bit 3: 0 reference pin, 1 supply.
// - Bit 2 switches temperature sensor.
// - Bit 1 switches bias generator.
// - Bit 0 drives reference buffer onto pin.
module arc_adc_ref_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_high,
  output logic [arc_pkg::ARC_BITS-1:0] dac_trial,
  output logic track_active,
  output logic converter_on,
  output logic converter_shutdown,
  output logic [arc_pkg::ARC_SEL_W-1:0] positive_channel_select,
  output logic [arc_pkg::ARC_SEL_W-1:0] negative_channel_select,
  output logic differential_mode,
  output logic ref_buffer_gain_unity,
  output logic ref_from_regulator,
  output logic ref_from_supply,
  output logic ref_from_pin,
  output logic temp_sensor_on,
  output logic bias_generator_on,
  output logic ref_buffer_drive
);
  import arc_pkg::*;

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction

  logic [7:0] ref_reg, ref_next;
  logic conv_en_reg, conv_en_next;
  logic done_reg, done_next;
  logic [ARC_SEL_W-1:0] pos_reg, pos_next, neg_reg, neg_next;
  logic [7:0] rdata_reg, rdata_next;
  arc_state_t state_reg, state_next;
  logic [4:0] track_cnt_reg, track_cnt_next;
  logic [ARC_BITS-1:0] trial_reg, trial_next, mask_reg, mask_next;
  logic [ARC_BITS-1:0] result_reg, result_next;
  logic track_reg, track_next;
  logic [ARC_BITS-1:0] kept;
  logic start_req, busy;

  // Register writes.
  always_comb begin
    ref_next = ref_reg;
    conv_en_next = conv_en_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    start_req = 1'b0;
    if (sfr_wr && sfr_hit(sfr_addr, ARC_ADDR_REF_CTRL)) begin
      ref_next = sfr_wdata & ARC_REF_WRITE_MASK;
    end
    if (sfr_wr && sfr_hit(sfr_addr, ARC_ADDR_CONV_CTRL)) begin
      conv_en_next = sfr_wdata[ARC_CONV_EN_BIT];
      start_req = sfr_wdata[ARC_CONV_START_BIT] & sfr_wdata[ARC_CONV_EN_BIT];
    end
    if (sfr_wr && sfr_hit(sfr_addr, ARC_ADDR_POS_SEL)) begin
      pos_next = sfr_wdata[ARC_SEL_W-1:0];
    end
    if (sfr_wr && sfr_hit(sfr_addr, ARC_ADDR_NEG_SEL)) begin
      neg_next = sfr_wdata[ARC_SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_reg <= ARC_REF_RESET;
      conv_en_reg <= 1'b0;
      pos_reg <= ARC_SEL_RESET;
      neg_reg <= ARC_SEL_RESET;
    end else begin
      ref_reg <= ref_next;
      conv_en_reg <= conv_en_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
    end
  end

  // Conversion sequencer: tracking then one bit per clock, 20 cycles per sample.
  assign busy = (state_reg != ARC_IDLE);
  assign kept = cmp_high ? trial_reg : (trial_reg & ~mask_reg);

  always_comb begin
    state_next = state_reg;
    track_cnt_next = track_cnt_reg;
    trial_next = trial_reg;
    mask_next = mask_reg;
    result_next = result_reg;
    done_next = done_reg;
    // A software clear loses to a completion in the same cycle.
    if (sfr_wr && sfr_hit(sfr_addr, ARC_ADDR_CONV_CTRL) && !sfr_wdata[ARC_CONV_DONE_BIT]) begin
      done_next = 1'b0;
    end
    case (state_reg)
      ARC_IDLE: begin
        if (start_req) begin
          state_next = ARC_TRACK;
          track_cnt_next = 5'(ARC_TRACK_CYCLES - 1);
          done_next = 1'b0;
        end
      end
      ARC_TRACK: begin
        if (track_cnt_reg == 5'h00) begin
          state_next = ARC_CONVERT;
          mask_next = {1'b1, {(ARC_BITS-1){1'b0}}};
          trial_next = {1'b1, {(ARC_BITS-1){1'b0}}};
        end else begin
          track_cnt_next = track_cnt_reg - 5'h01;
        end
      end
      ARC_CONVERT: begin
        mask_next = mask_reg >> 1;
        trial_next = kept | (mask_reg >> 1);
        if (mask_reg[0]) begin
          result_next = kept;
          done_next = 1'b1;
          state_next = ARC_IDLE;
          trial_next = {ARC_BITS{1'b0}};
        end
      end
      default: begin
        state_next = ARC_IDLE;
      end
    endcase
    if (!conv_en_next) begin
      // Shutdown aborts a conversion in flight; the result keeps its last value.
      state_next = ARC_IDLE;
      trial_next = {ARC_BITS{1'b0}};
      mask_next = {ARC_BITS{1'b0}};
    end
    track_next = (state_next == ARC_TRACK);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ARC_IDLE;
      track_cnt_reg <= 5'h00;
      trial_reg <= {ARC_BITS{1'b0}};
      mask_reg <= {ARC_BITS{1'b0}};
      result_reg <= {ARC_BITS{1'b0}};
      done_reg <= 1'b0;
      track_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      track_cnt_reg <= track_cnt_next;
      trial_reg <= trial_next;
      mask_reg <= mask_next;
      result_reg <= result_next;
      done_reg <= done_next;
      track_reg <= track_next;
    end
  end

  // Read port; data is registered so it appears the cycle after the strobe.
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      rdata_next = 8'h00;
      case (sfr_addr)
        ARC_ADDR_REF_CTRL: rdata_next = ref_reg & ARC_REF_WRITE_MASK;
        ARC_ADDR_CONV_CTRL: begin
          rdata_next[ARC_CONV_EN_BIT] = conv_en_reg;
          rdata_next[ARC_CONV_DONE_BIT] = done_reg;
          rdata_next[ARC_CONV_START_BIT] = busy;
        end
        ARC_ADDR_POS_SEL: rdata_next = {3'h0, pos_reg};
        ARC_ADDR_NEG_SEL: rdata_next = {3'h0, neg_reg};
        ARC_ADDR_RESULT_HI: rdata_next = {6'h00, result_reg[9:8]};
        ARC_ADDR_RESULT_LO: rdata_next = result_reg[7:0];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Analog controls are flopped copies of the stored settings, so they follow a write
  // by two edges with no combinational path from the bus to the analog macro.
  logic [11:0] ana_reg, ana_next;
  always_comb begin
    // The enable pair follows the write edge itself, like the sequencer, so the macro
    // is never held in shutdown while a conversion is tracking.
    ana_next[0] = conv_en_next;
    ana_next[1] = ~conv_en_next;
    ana_next[2] = (neg_reg != ARC_NEG_GND);
    ana_next[3] = ref_reg[ARC_REF_GAIN_BIT];
    ana_next[4] = ref_reg[ARC_REF_REGULATOR_REF_OVERRIDE_BIT];
    ana_next[5] = ~ref_reg[ARC_REF_REGULATOR_REF_OVERRIDE_BIT] & ref_reg[ARC_REF_SRC_BIT];
    ana_next[6] = ~ref_reg[ARC_REF_REGULATOR_REF_OVERRIDE_BIT] & ~ref_reg[ARC_REF_SRC_BIT];
    ana_next[7] = ref_reg[ARC_REF_TEMP_BIT];
    ana_next[8] = ref_reg[ARC_REF_BIAS_BIT];
    ana_next[9] = ref_reg[ARC_REF_BUF_BIT];
    ana_next[11:10] = 2'h0;
  end

  logic [ARC_SEL_W-1:0] pos_out_reg, neg_out_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ana_reg <= 12'h042;
      pos_out_reg <= ARC_SEL_RESET;
      neg_out_reg <= ARC_SEL_RESET;
    end else begin
      ana_reg <= ana_next;
      pos_out_reg <= pos_reg;
      neg_out_reg <= neg_reg;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign dac_trial = trial_reg;
  assign track_active = track_reg;
  assign converter_on = ana_reg[0];
  assign converter_shutdown = ana_reg[1];
  assign positive_channel_select = pos_out_reg;
  assign negative_channel_select = neg_out_reg;
  assign differential_mode = ana_reg[2];
  assign ref_buffer_gain_unity = ana_reg[3];
  assign ref_from_regulator = ana_reg[4];
  assign ref_from_supply = ana_reg[5];
  assign ref_from_pin = ana_reg[6];
  assign temp_sensor_on = ana_reg[7];
  assign bias_generator_on = ana_reg[8];
  assign ref_buffer_drive = ana_reg[9];
endmodule // arc_adc_ref_ctrl

// File: logic/arc_pkg.sv
package arc_pkg;
  localparam int ARC_CLK_HZ = 10000000;
  localparam int ARC_SAMPLE_RATE_SPS = 500000;
  localparam int ARC_BITS = 10;
  localparam int ARC_CONV_CYCLES = ARC_CLK_HZ / ARC_SAMPLE_RATE_SPS;
  localparam int ARC_TRACK_CYCLES = ARC_CONV_CYCLES - ARC_BITS;
  localparam logic [7:0] ARC_ADDR_REF_CTRL = 8'hD1;
  localparam logic [7:0] ARC_ADDR_CONV_CTRL = 8'hE8;
  localparam logic [7:0] ARC_ADDR_POS_SEL = 8'hBB;
  localparam logic [7:0] ARC_ADDR_NEG_SEL = 8'hBA;
  localparam logic [7:0] ARC_ADDR_RESULT_HI = 8'hBE;
  localparam logic [7:0] ARC_ADDR_RESULT_LO = 8'hBD;
  localparam int ARC_REF_GAIN_BIT = 7;
  localparam int ARC_REF_REGULATOR_REF_OVERRIDE_BIT = 4;
  localparam int ARC_REF_SRC_BIT = 3;
  localparam int ARC_REF_TEMP_BIT = 2;
  localparam int ARC_REF_BIAS_BIT = 1;
  localparam int ARC_REF_BUF_BIT = 0;
  localparam logic [7:0] ARC_REF_WRITE_MASK = 8'h9F;
  localparam logic [7:0] ARC_REF_RESET = 8'h00;
  localparam int ARC_CONV_EN_BIT = 7;
  localparam int ARC_CONV_DONE_BIT = 5;
  localparam int ARC_CONV_START_BIT = 4;
  localparam int ARC_SEL_W = 5;
  localparam logic [4:0] ARC_POS_TEMP = 5'h1E;
  localparam logic [4:0] ARC_POS_VDD = 5'h1F;
  localparam logic [4:0] ARC_NEG_VREF = 5'h1E;
  localparam logic [4:0] ARC_NEG_GND = 5'h1F;
  localparam logic [4:0] ARC_SEL_RESET = 5'h00;
  typedef enum logic [1:0] {
    ARC_IDLE = 2'b00,
    ARC_TRACK = 2'b01,
    ARC_CONVERT = 2'b11
  } arc_state_t;
endpackage
